// File: design/pbsc_sram_control.sv
// control logic of a pipelined burst sram: cycle decode, burst addressing,
// byte-lane writes, two-stage read pipeline, output gating and sleep handling
// assumes the array answers a read combinationally from o_array_addr and
// that every input, the output enable and sleep included, is synchronous
`default_nettype none

// What this block does
// - controller strobe, or processor strobe with primary select active, deselects when any chip select is inactive
// - processor strobe begins read at external address
// - controller strobe begins write or read
// - no strobe, advance low, read: continue read
// - no strobe, advance low, write: continue write
// - no strobe, advance high, read: repeat current
// - no strobe, advance high, write: write current
// - decoded write low means a write
// - read when global high, master or lanes high
// - global write low writes all lanes
// - master low writes only the enabled lanes
// - sleep and output enable override the outputs
// - sleep enters and exits after two cycles
// - burst order linear or interleaved from start
// - read data passes two pipeline registers
// - advance and writes ignored on processor strobe
// - controller strobe samples writes same edge
module pbsc_sram_control (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst,
  input  wire pbsc_pkg::pbsc_ctl_s           i_ctl,
  input  wire logic [pbsc_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [pbsc_pkg::DATA_W-1:0]   i_wdata,
  input  wire logic                          i_output_enable_n,
  input  wire logic                          i_sleep_request,
  input  wire logic                          i_burst_order_select,
  input  wire logic [pbsc_pkg::DATA_W-1:0]   i_array_rdata,
  output var  logic [pbsc_pkg::ADDR_W-1:0]   o_array_addr,
  output var  logic                          o_array_rd,
  output var  logic [pbsc_pkg::LANES-1:0]    o_array_we,
  output var  logic [pbsc_pkg::DATA_W-1:0]   o_array_wdata,
  output var  logic [pbsc_pkg::DATA_W-1:0]   o_dq_out,
  output var  logic                          o_dq_oe,
  output var  logic                          o_power_down,
  output var  logic                          o_burst_active
);

  // decode results
  pbsc_pkg::pbsc_op_e op;                        // operation on this edge
  logic               strobe_seen;               // a strobe starts something
  logic               all_selected;              // every chip select active
  logic               accepting;                 // not asleep nor waking
  logic [pbsc_pkg::LANES-1:0]   lane_we;         // decoded lane enables
  logic                         write_n;         // decoded write, low writes
  logic [pbsc_pkg::BURST_W-1:0] low_bits;        // burst low bits this access
  logic                         is_begin;        // begin of a burst
  logic                         is_adv;          // counter steps
  logic                         is_write;        // array write this edge
  logic                         is_read;         // array read this edge

  // state
  pbsc_pkg::pbsc_pm_e              pm_ff;        // power management state
  logic [pbsc_pkg::PD_CNT_W-1:0]   pm_cnt_ff;    // cycles spent in a transition
  logic [pbsc_pkg::ADDR_W-1:0]     hi_addr_ff;   // upper address of the burst
  logic                            stage1_vld_ff;
  logic [pbsc_pkg::DATA_W-1:0]     stage1_ff;    // data-out register

  // byte-lane write decode
  pbsc_write_decode u_write_decode (
    .i_global_write_n      (i_ctl.global_write_n),
    .i_byte_write_master_n (i_ctl.byte_write_master_n),
    .i_lane_write_n        (i_ctl.lane_write_n),
    .o_lane_we             (lane_we),
    .o_write_n             (write_n)
  );

  // burst counter steps only on continue cycles, holds on suspend
  pbsc_burst_counter u_burst_counter (
    .i_core_clk           (i_core_clk),
    .i_rst                (i_rst),
    .i_load               (is_begin),
    .i_advance            (is_adv),
    .i_burst_start_bits   (i_addr[pbsc_pkg::BURST_W-1:0]),
    .i_burst_order_select (i_burst_order_select),
    .o_low_bits           (low_bits)
  );

  // accesses are refused while powered down and during the wake interval
  always_comb begin
    accepting = (pm_ff == pbsc_pkg::PM_RUN) || (pm_ff == pbsc_pkg::PM_ENTER);
  end

  // chip selects and strobes; processor strobe is blocked by the primary select
  always_comb begin
    all_selected = ~i_ctl.primary_chip_select_n & i_ctl.secondary_chip_select
                 & ~i_ctl.tertiary_chip_select_n;
    strobe_seen  = (~i_ctl.processor_addr_strobe_n & ~i_ctl.primary_chip_select_n)
                 | ~i_ctl.controller_addr_strobe_n;
  end

  // synchronous cycle decode
  always_comb begin
    op = pbsc_pkg::OP_IDLE;
    if (!accepting) begin
      op = pbsc_pkg::OP_IDLE;
    end else if (strobe_seen) begin
      if (!all_selected) begin
        op = pbsc_pkg::OP_DESEL;
      end else if (!i_ctl.processor_addr_strobe_n) begin
        // advance and write inputs are not looked at on this edge
        op = pbsc_pkg::OP_BEGIN_RD;
      end else if (!write_n) begin
        op = pbsc_pkg::OP_BEGIN_WR;
      end else begin
        op = pbsc_pkg::OP_BEGIN_RD;
      end
    end else if (o_burst_active) begin
      // no new cycle: advance and decoded write steer the open burst
      case ({i_ctl.burst_advance_n, write_n})
        2'b01:   op = pbsc_pkg::OP_CONT_RD;
        2'b00:   op = pbsc_pkg::OP_CONT_WR;
        2'b11:   op = pbsc_pkg::OP_SUSP_RD;
        2'b10:   op = pbsc_pkg::OP_SUSP_WR;
        default: op = pbsc_pkg::OP_IDLE;
      endcase
    end
  end

  // classify the operation for the datapath
  always_comb begin
    is_begin = (op == pbsc_pkg::OP_BEGIN_RD) || (op == pbsc_pkg::OP_BEGIN_WR);
    is_adv   = (op == pbsc_pkg::OP_CONT_RD) || (op == pbsc_pkg::OP_CONT_WR);
    is_write = (op == pbsc_pkg::OP_BEGIN_WR) || (op == pbsc_pkg::OP_CONT_WR)
             || (op == pbsc_pkg::OP_SUSP_WR);
    is_read  = (op == pbsc_pkg::OP_BEGIN_RD) || (op == pbsc_pkg::OP_CONT_RD)
             || (op == pbsc_pkg::OP_SUSP_RD);
  end

  // sleep entry and exit, each a fixed two-cycle walk
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pm_ff     <= pbsc_pkg::PM_RUN;
      pm_cnt_ff <= '0;
    end else begin
      case (pm_ff)
        pbsc_pkg::PM_RUN: begin
          if (i_sleep_request) begin
            pm_ff     <= pbsc_pkg::PM_ENTER;
            pm_cnt_ff <= pbsc_pkg::PD_CNT_FIRST;
          end
        end
        pbsc_pkg::PM_ENTER: begin
          // a short pulse on sleep aborts the entry
          if (!i_sleep_request) begin
            pm_ff <= pbsc_pkg::PM_RUN;
          end else if (pm_cnt_ff == pbsc_pkg::PD_ENTRY_LAST) begin
            pm_ff <= pbsc_pkg::PM_DOWN;
          end else begin
            pm_cnt_ff <= pm_cnt_ff + pbsc_pkg::PD_CNT_FIRST;
          end
        end
        pbsc_pkg::PM_DOWN: begin
          if (!i_sleep_request) begin
            pm_ff     <= pbsc_pkg::PM_WAKE;
            pm_cnt_ff <= pbsc_pkg::PD_CNT_FIRST;
          end
        end
        pbsc_pkg::PM_WAKE: begin
          // sleep again during wake-up goes straight back down
          if (i_sleep_request) begin
            pm_ff <= pbsc_pkg::PM_DOWN;
          end else if (pm_cnt_ff == pbsc_pkg::PD_EXIT_LAST) begin
            pm_ff <= pbsc_pkg::PM_RUN;
          end else begin
            pm_cnt_ff <= pm_cnt_ff + pbsc_pkg::PD_CNT_FIRST;
          end
        end
        default: begin
          pm_ff <= pbsc_pkg::PM_RUN;
        end
      endcase
    end
  end

  // power-down flag follows the state, so it lags sleep by two edges
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_power_down <= 1'b0;
    end else begin
      o_power_down <= (pm_ff == pbsc_pkg::PM_DOWN)
                    || (pm_ff == pbsc_pkg::PM_ENTER && i_sleep_request
                        && pm_cnt_ff == pbsc_pkg::PD_ENTRY_LAST)
                    || (pm_ff == pbsc_pkg::PM_WAKE
                        && (i_sleep_request || pm_cnt_ff != pbsc_pkg::PD_EXIT_LAST));
    end
  end

  // open burst: set by a begin, cleared by a deselect; sleep keeps it
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_burst_active <= 1'b0;
    end else if (is_begin) begin
      o_burst_active <= 1'b1;
    end else if (op == pbsc_pkg::OP_DESEL) begin
      o_burst_active <= 1'b0;
    end
  end

  // upper address is captured only when a burst begins
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      hi_addr_ff <= pbsc_pkg::ADDR_RST;
    end else if (is_begin) begin
      hi_addr_ff <= i_addr;
    end
  end

  // array request: address, read strobe, lane enables and write data
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_array_addr  <= pbsc_pkg::ADDR_RST;
      o_array_rd    <= 1'b0;
      o_array_we    <= pbsc_pkg::LANE_RST;
      o_array_wdata <= pbsc_pkg::DATA_RST;
    end else begin
      o_array_rd <= is_read;
      o_array_we <= is_write ? lane_we : pbsc_pkg::LANE_RST;
      if (is_read || is_write) begin
        // begin takes the external address, later cycles the held one
        o_array_addr <= is_begin
          ? {i_addr[pbsc_pkg::ADDR_W-1:pbsc_pkg::BURST_W], low_bits}
          : {hi_addr_ff[pbsc_pkg::ADDR_W-1:pbsc_pkg::BURST_W], low_bits};
      end
      if (is_write) begin
        o_array_wdata <= i_wdata;
      end
    end
  end

  // read pipeline, first stage: array data into the data-out register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      stage1_vld_ff <= 1'b0;
      stage1_ff     <= pbsc_pkg::DATA_RST;
    end else begin
      stage1_vld_ff <= o_array_rd;
      if (o_array_rd) begin
        stage1_ff <= i_array_rdata;
      end
    end
  end

  // second stage: data-out buffer drives the pins on the following edge
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dq_out <= pbsc_pkg::DATA_RST;
    end else if (stage1_vld_ff) begin
      o_dq_out <= stage1_ff;
    end
  end

  // output enable: sleep, output-enable pin and a write cycle all force
  // high-z; the pins are sampled here, so the override lands one edge late
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dq_oe <= 1'b0;
    end else begin
      o_dq_oe <= stage1_vld_ff && !i_output_enable_n && !i_sleep_request
               && !o_power_down && !is_write;
    end
  end

endmodule : pbsc_sram_control

`default_nettype wire

// File: pkg/pbsc_pkg.sv
// shared constants, enumerations and the control-pin bundle of the burst sram control block
// assumes a single 125 MHz core clock; every pin is synchronous to it
`default_nettype none

package pbsc_pkg;

  // array geometry: four byte lanes of eight data bits plus one parity bit each
  localparam int unsigned LANES      = 4;
  localparam int unsigned LANE_W     = 9;
  localparam int unsigned DATA_W     = LANES * LANE_W;
  localparam int unsigned ADDR_W     = 18;
  localparam int unsigned BURST_W    = 2;

  // power-down entry and exit, counted in clock cycles
  localparam int unsigned PD_ENTRY_CYC = 2;
  localparam int unsigned PD_EXIT_CYC  = 2;
  localparam int unsigned PD_CNT_W     = 2;
  localparam logic [PD_CNT_W-1:0] PD_ENTRY_LAST = PD_CNT_W'(PD_ENTRY_CYC - 1);
  localparam logic [PD_CNT_W-1:0] PD_EXIT_LAST  = PD_CNT_W'(PD_EXIT_CYC - 1);
  localparam logic [PD_CNT_W-1:0] PD_CNT_FIRST  = 2'h1;

  // burst counter step and order encodings
  localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;
  localparam logic               ORDER_LINEAR = 1'h0;

  // reset values
  localparam logic [ADDR_W-1:0]  ADDR_RST = 18'h00000;
  localparam logic [DATA_W-1:0]  DATA_RST = 36'h000000000;
  localparam logic [LANES-1:0]   LANE_RST = 4'h0;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;

  // operation decoded on one clock edge
  typedef enum logic [2:0] {
    OP_IDLE,
    OP_DESEL,
    OP_BEGIN_RD,
    OP_BEGIN_WR,
    OP_CONT_RD,
    OP_CONT_WR,
    OP_SUSP_RD,
    OP_SUSP_WR
  } pbsc_op_e;

  // power management states
  typedef enum logic [1:0] {
    PM_RUN,
    PM_ENTER,
    PM_DOWN,
    PM_WAKE
  } pbsc_pm_e;

  // synchronous control pins of the bus, all sampled on the rising edge
  typedef struct packed {
    logic             primary_chip_select_n;
    logic             secondary_chip_select;
    logic             tertiary_chip_select_n;
    logic             processor_addr_strobe_n;
    logic             controller_addr_strobe_n;
    logic             burst_advance_n;
    logic             global_write_n;
    logic             byte_write_master_n;
    logic [LANES-1:0] lane_write_n;
  } pbsc_ctl_s;

endpackage : pbsc_pkg

`default_nettype wire

// File: design/pbsc_write_decode.sv
// byte-lane write decode: global write, byte-write master and lane enables
// purely combinational; the caller samples the result on its clock edge
`default_nettype none

module pbsc_write_decode (
  input  wire logic                     i_global_write_n,
  input  wire logic                     i_byte_write_master_n,
  input  wire logic [pbsc_pkg::LANES-1:0] i_lane_write_n,
  output var  logic [pbsc_pkg::LANES-1:0] o_lane_we,
  output var  logic                     o_write_n
);

  // one enable per lane, parity bit travels with its lane
  for (genvar g = 0; g < pbsc_pkg::LANES; g++) begin : g_lane
    // global write overrides everything, else master plus the lane's own enable
    always_comb begin
      o_lane_we[g] = ~i_global_write_n | (~i_byte_write_master_n & ~i_lane_write_n[g]);
    end
  end

  // read when global write is high and master high or no lane selected
  always_comb begin
    o_write_n = i_global_write_n & (i_byte_write_master_n | (&i_lane_write_n));
  end

endmodule : pbsc_write_decode

`default_nettype wire

// File: design/pbsc_burst_counter.sv
// two-bit burst address counter with linear or interleaved order
// start bits are loaded on a begin cycle; order strap is a static level
`default_nettype none

module pbsc_burst_counter (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_load,
  input  wire logic                       i_advance,
  input  wire logic [pbsc_pkg::BURST_W-1:0] i_burst_start_bits,
  input  wire logic                       i_burst_order_select,
  output var  logic [pbsc_pkg::BURST_W-1:0] o_low_bits
);

  logic [pbsc_pkg::BURST_W-1:0] start_ff;  // low bits given at burst start
  logic [pbsc_pkg::BURST_W-1:0] count_ff;  // advances made since start, wraps
  logic [pbsc_pkg::BURST_W-1:0] nxt_count; // count used by this access

  // count for this access: zero on load, one more on advance, same on suspend
  always_comb begin
    if (i_load) begin
      nxt_count = pbsc_pkg::BURST_RST;
    end else if (i_advance) begin
      nxt_count = count_ff + pbsc_pkg::BURST_STEP;
    end else begin
      nxt_count = count_ff;
    end
  end

  // linear adds, interleaved xors; both wrap to the start after four
  always_comb begin
    if (i_load) begin
      o_low_bits = i_burst_start_bits;
    end else if (i_burst_order_select == pbsc_pkg::ORDER_LINEAR) begin
      o_low_bits = start_ff + nxt_count;
    end else begin
      o_low_bits = start_ff ^ nxt_count;
    end
  end

  // start bits held for the life of the burst
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      start_ff <= pbsc_pkg::BURST_RST;
    end else if (i_load) begin
      start_ff <= i_burst_start_bits;
    end
  end

  // counter wraps naturally at two bits
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      count_ff <= pbsc_pkg::BURST_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

endmodule : pbsc_burst_counter

`default_nettype wire

// File: dv/pbsc_sram_control_asserts.sv
// checker for the burst sram control block
// bound to the control top module and sees its ports only
`default_nettype none

module pbsc_sram_control_asserts (
  input wire logic                i_core_clk,
  input wire logic                i_rst,
  input wire pbsc_pkg::pbsc_ctl_s i_ctl,
  input wire logic [17:0]         i_addr,
  input wire logic [35:0]         i_wdata,
  input wire logic                i_output_enable_n,
  input wire logic                i_sleep_request,
  input wire logic                i_burst_order_select,
  input wire logic [35:0]         i_array_rdata,
  input wire logic [17:0]         o_array_addr,
  input wire logic                o_array_rd,
  input wire logic [3:0]          o_array_we,
  input wire logic [35:0]         o_array_wdata,
  input wire logic [35:0]         o_dq_out,
  input wire logic                o_dq_oe,
  input wire logic                o_power_down,
  input wire logic                o_burst_active
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       p_n, c_n, v_n, g_n, b_n;  // short aliases of the control pins
  logic [3:0] l_n;                      // lane enables
  logic       al, st, ns, rdd, aw, bo;  // all selected, strobe, no strobe, read decode, awake, open
  logic [1:0] wk_ff;                    // sleep-low samples, saturating at 3
  logic       ns_ff;                    // previous edge had no strobe

  assign p_n = i_ctl.processor_addr_strobe_n;
  assign c_n = i_ctl.controller_addr_strobe_n;
  assign v_n = i_ctl.burst_advance_n;
  assign g_n = i_ctl.global_write_n;
  assign b_n = i_ctl.byte_write_master_n;
  assign l_n = i_ctl.lane_write_n;
  assign al  = !i_ctl.primary_chip_select_n && i_ctl.secondary_chip_select && !i_ctl.tertiary_chip_select_n;
  assign st  = (!p_n && !i_ctl.primary_chip_select_n) || !c_n;
  assign ns  = !st;
  assign rdd = g_n && (b_n || (&l_n));
  // judge strobes clear of wake-up
  assign aw  = (wk_ff == 2'h3) && !o_power_down;
  // a stale open flag right after a deselect is excluded by ns_ff
  assign bo  = aw && o_burst_active && ns && ns_ff;

  // counts how long sleep has stayed low
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wk_ff <= 2'h0;
    end else if (i_sleep_request) begin
      wk_ff <= 2'h0;
    end else if (wk_ff != 2'h3) begin
      wk_ff <= wk_ff + 2'h1;
    end
  end

  // no strobe seen on the last edge
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ns_ff <= 1'b0;
    end else begin
      ns_ff <= ns;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  chk_desel_quiet: assert property (aw && st && !al |-> ##1 !o_array_rd && o_array_we == 4'h0)
    else $error("deselect accessed");
  chk_begin_read: assert property (aw && al && !p_n |-> ##1 o_array_rd && o_array_we == 4'h0 && o_array_addr == $past(i_addr))
    else $error("no begin read");
  chk_begin_write: assert property (aw && al && p_n && !c_n && !g_n |-> ##1 o_array_we == 4'hF && o_array_wdata == $past(i_wdata) && o_array_addr == $past(i_addr))
    else $error("begin write wrong");
  chk_lane_write: assert property (aw && al && p_n && !c_n && g_n && !b_n |-> ##1 o_array_we == ~$past(l_n))
    else $error("lane enables wrong");
  chk_read_decode: assert property (aw && al && p_n && !c_n && rdd |-> ##1 o_array_rd && o_array_we == 4'h0)
    else $error("no decoded read");
  chk_pipe_data: assert property (o_array_rd |-> ##2 o_dq_out == $past(i_array_rdata, 2))
    else $error("read pipe wrong");
  chk_cont_read: assert property (bo && !v_n && rdd && !i_burst_order_select |-> ##1 o_array_rd && o_array_addr[1:0] == $past(o_array_addr[1:0]) + 2'h1)
    else $error("cont read addr");
  chk_cont_write: assert property (bo && !v_n && !g_n && !i_burst_order_select |-> ##1 o_array_we == 4'hF && o_array_addr[1:0] == $past(o_array_addr[1:0]) + 2'h1)
    else $error("cont write addr");
  chk_susp_read: assert property (bo && v_n && rdd |-> ##1 o_array_rd && $stable(o_array_addr))
    else $error("suspend read moved");
  chk_susp_write: assert property (bo && v_n && !g_n |-> ##1 o_array_we == 4'hF && $stable(o_array_addr))
    else $error("suspend write moved");
  chk_sleep_enter: assert property (aw && i_sleep_request ##1 i_sleep_request |=> o_power_down)
    else $error("no power-down");
  chk_sleep_exit: assert property (!i_sleep_request ##1 !i_sleep_request |=> !o_power_down)
    else $error("power-down stuck");
  chk_oe_gate: assert property ((i_output_enable_n || i_sleep_request) [*2] |=> !o_dq_oe)
    else $error("outputs not off");

  cov_begin_write: cover property (aw && al && p_n && !c_n && !g_n);
  cov_cont_ileave: cover property (bo && !v_n && rdd && i_burst_order_select);
  cov_sleep: cover property (o_power_down);
endmodule : pbsc_sram_control_asserts

bind pbsc_sram_control pbsc_sram_control_asserts u_pbsc_sram_control_asserts (
  .i_core_clk, .i_rst, .i_ctl, .i_addr, .i_wdata, .i_output_enable_n, .i_sleep_request,
  .i_burst_order_select, .i_array_rdata, .o_array_addr, .o_array_rd, .o_array_we, .o_array_wdata,
  .o_dq_out, .o_dq_oe, .o_power_down, .o_burst_active);

`default_nettype wire

// File: dv/pbsc_array_model.sv
// behavioural array behind the control block: 16 words, nine-bit lane writes
// assumes address, read and lane strobes arrive as registered one-cycle pulses
`default_nettype none

module pbsc_array_model (
  input  wire logic        i_core_clk,
  input  wire logic [17:0] i_addr,
  input  wire logic        i_rd,
  input  wire logic [3:0]  i_we,
  input  wire logic [35:0] i_wdata,
  output var  logic [35:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [35:0] mem [16];  // word i holds i in every nibble

  initial for (int i = 0; i < 16; i++) mem[i] = {9{4'(i)}};

  // each lane carries its parity bit with its byte
  always @(posedge i_core_clk) begin
    for (int l = 0; l < 4; l++) if (i_we[l]) mem[i_addr[3:0]][9*l +: 9] <= i_wdata[9*l +: 9];
  end

  // outside a read the bus shows inverted data, so a stray capture shows up
  assign o_rdata = i_rd ? mem[i_addr[3:0]] : ~mem[i_addr[3:0]];
endmodule : pbsc_array_model

`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the burst sram control block with an array model
// assumes the package is compiled first; inputs change on the falling edge
`default_nettype none

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                i_core_clk, i_rst, i_output_enable_n, i_sleep_request, i_burst_order_select;
  pbsc_pkg::pbsc_ctl_s i_ctl;
  logic [17:0]         i_addr, o_array_addr;
  logic [35:0]         i_wdata, i_array_rdata, o_array_wdata, o_dq_out;
  logic [3:0]          o_array_we;
  logic                o_array_rd, o_dq_oe, o_power_down, o_burst_active;
  int                  mismatches, checks_done;
  pbsc_pkg::pbsc_ctl_s q_ctl [16];          // queued requests
  logic [17:0]         q_addr [16], e_addr [16];
  logic [35:0]         q_data [16], e_dq [16];
  logic [3:0]          e_we [16];
  logic                e_rd [16], e_dqv [16];

  pbsc_sram_control u_pbsc_sram_control (.i_core_clk, .i_rst, .i_ctl, .i_addr, .i_wdata, .i_output_enable_n,
    .i_sleep_request, .i_burst_order_select, .i_array_rdata, .o_array_addr, .o_array_rd, .o_array_we,
    .o_array_wdata, .o_dq_out, .o_dq_oe, .o_power_down, .o_burst_active);
  pbsc_array_model u_pbsc_array_model (.i_core_clk, .i_addr(o_array_addr), .i_rd(o_array_rd),
    .i_we(o_array_we), .i_wdata(o_array_wdata), .o_rdata(i_array_rdata));

  // control pins; s gives the three selects as inactive flags {primary, secondary, tertiary}
  function automatic pbsc_pkg::pbsc_ctl_s mk(input logic [2:0] s, input logic p, c, v, g, b, input logic [3:0] l);
    mk = '{s[2], !s[1], s[0], p, c, v, g, b, l};
  endfunction : mk

  // idle queue, no expected access
  task automatic clr;
    for (int k = 0; k < 16; k++) begin
      q_ctl[k] = mk(3'b000, 1, 1, 1, 1, 1, 4'hF);
      q_addr[k] = 18'h3FFFF;
      q_data[k] = 36'hA5A5A5A50 + 36'(k);
      e_we[k] = 4'h0;
      e_rd[k] = 1'b0;
      e_dqv[k] = 1'b0;
    end
  endtask : clr

  // plays n requests; access seen one cycle on, read data three
  task automatic run(input int n);
    for (int t = 0; t < n + 4; t++) begin
      if (t >= 1 && t < n + 1) begin
        `CHK(o_array_rd, e_rd[t-1])
        `CHK(o_array_we, e_we[t-1])
        if (e_rd[t-1] || |e_we[t-1]) `CHK(o_array_addr, e_addr[t-1])
        if (|e_we[t-1]) `CHK(o_array_wdata, q_data[t-1])
      end
      if (t >= 3 && e_dqv[t-3]) begin
        `CHK(o_dq_out, e_dq[t-3])
        `CHK(o_dq_oe, 1'b1)
      end
      i_ctl = t < n ? q_ctl[t] : mk(3'b000, 1, 1, 1, 1, 1, 4'hF);
      i_addr = t < n ? q_addr[t] : 18'h3FFFF;
      i_wdata = q_data[t < n ? t : 15];
      @(negedge i_core_clk);
    end
  endtask : run

  // processor-strobe read wrapping past four beats, a suspend, then a deselect
  task automatic sc_read(input logic ord, input logic [1:0] st);
    logic [1:0] lo;
    clr();
    i_burst_order_select = ord;
    i_output_enable_n = 1'b0;
    for (int k = 0; k < 7; k++) begin
      lo = ord ? st ^ 2'(k == 6 ? 5 : k) : st + 2'(k == 6 ? 5 : k);
      // write and advance inputs are set on the begin edge to show they are ignored
      q_ctl[k] = k == 0 ? mk(3'b000, 0, 0, 0, 0, 0, 4'h0) : mk(3'b000, 1, 1, k == 6, 1, 1, 4'hF);
      e_addr[k] = {16'h2AB3, lo};
      e_rd[k] = 1'b1;
      e_dqv[k] = 1'b1;
      e_dq[k] = {9{e_addr[k][3:0]}};
    end
    q_addr[0] = {16'h2AB3, st};
    q_ctl[7] = mk(3'b100, 1, 0, 1, 1, 1, 4'hF);
    run(8);
  endtask : sc_read

  // controller-strobe write burst across the wrap: global, lanes, global, suspend
  task automatic sc_write;
    clr();
    i_burst_order_select = 1'b0;
    i_output_enable_n = 1'b1;
    @(negedge i_core_clk);
    q_ctl[0] = mk(3'b000, 1, 0, 1, 0, 1, 4'hF);
    q_ctl[1] = mk(3'b000, 1, 1, 0, 1, 0, 4'hA);
    q_ctl[2] = mk(3'b000, 1, 1, 0, 0, 1, 4'hF);
    q_ctl[3] = mk(3'b000, 1, 1, 1, 0, 1, 4'hF);
    q_ctl[4] = mk(3'b010, 0, 1, 1, 1, 1, 4'hF);
    q_addr[0] = 18'h00007;
    e_we[0:3] = '{4'hF, 4'h5, 4'hF, 4'hF};
    e_addr[0:3] = '{18'h00007, 18'h00004, 18'h00005, 18'h00005};
    run(5);
    `CHK(o_dq_oe, 1'b0)
  endtask : sc_write

  // every lane pattern under the byte-write master, the master off, and deselect forms
  task automatic sc_lanes;
    for (int l = 0; l < 17; l++) begin
      clr();
      q_ctl[0] = mk(3'b000, 1, 0, 1, 1, l == 16, 4'(l));
      q_ctl[1] = mk(l[0] ? 3'b001 : 3'b010, l[1], !l[1], 1, 1, 1, 4'hF);
      q_addr[0] = 18'(l);
      e_addr[0] = 18'(l);
      e_we[0] = l == 16 ? 4'h0 : ~4'(l);
      e_rd[0] = l >= 15;
      run(2);
    end
  endtask : sc_lanes

  // two-cycle entry, a refused strobe while down, two-cycle exit, strobe at the boundary
  task automatic sc_sleep;
    clr();
    i_output_enable_n = 1'b0;
    i_sleep_request = 1'b1;
    @(negedge i_core_clk);
    `CHK(o_power_down, 1'b0)
    @(negedge i_core_clk);
    `CHK(o_power_down, 1'b1)
    q_ctl[0] = mk(3'b000, 0, 1, 1, 1, 1, 4'hF);
    q_addr[0] = 18'h0000F;
    run(1);
    `CHK(o_dq_oe, 1'b0)
    i_sleep_request = 1'b0;
    repeat (2) @(negedge i_core_clk);
    `CHK(o_power_down, 1'b0)
    // first strobe only after the two wake-up cycles
    q_ctl[1] = mk(3'b100, 1, 0, 1, 1, 1, 4'hF);
    e_rd[0] = 1'b1;
    e_addr[0] = 18'h0000F;
    e_dqv[0] = 1'b1;
    e_dq[0] = {9{4'hF}};
    run(2);
  endtask : sc_sleep

  // prints the counts and the verdict, then stops
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  // 125 MHz core clock
  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  // reset, then the scenarios in turn
  initial begin
    mismatches = 0;
    checks_done = 0;
    i_rst = 1'b1;
    i_ctl = mk(3'b000, 1, 1, 1, 1, 1, 4'hF);
    i_addr = 18'h0;
    i_wdata = 36'h0;
    i_output_enable_n = 1'b1;
    i_sleep_request = 1'b0;
    i_burst_order_select = 1'b0;
    repeat (12) @(negedge i_core_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_core_clk);
    sc_read(1'b0, 2'h2);
    sc_read(1'b1, 2'h1);
    sc_write();
    sc_lanes();
    sc_sleep();
    results();
  end

  // whole run needs under two hundred cycles; a hang stops here
  initial begin
    repeat (3000) @(posedge i_core_clk);
    mismatches++;
    results();
  end
endmodule : testbench

`default_nettype wire
